// File: hw/mfi_decoder.sv
// Multifunction digital input decoder: filter, polarity, function decode
`default_nettype none
// Overview of operation
// - Mode one: forward, reverse, both means stop
// - Mode two: run/stop input plus direction input
// - Three-wire: first three terminals fixed roles
// - Functions 4,3,2 form preset speed index
// - Jog forward/reverse; both means stop
// - Up/down step, clamp at limit and zero
// - Short press steps; held two seconds ramps
// - Function 10 selects second ramp set
// - Function 11 holds present frequency
// - Function 12 selects alternative run source
// - Function 13 selects alternative frequency source
// - Rapid stop latches until new run
// - Coast block; release sweeps around set frequency
// - Function 16 disables PID
// - Function 17 resets manual fault
// - Function 18 enables auto sequencer when assigned (only terminals four, five in three-wire), whatever the terminal level
// - Keep-status decides frequency after stop
// - Settings 0,2 copy frequency to keypad
// - Setting 1 starts from zero frequency
// - Per-terminal 1ms noise filter, 1..400
// - Per-terminal normally open/closed polarity
module mfi_decoder import mfi_pkg::*; #(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int NTERM = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic input_terminal_one,
  input wire logic input_terminal_two,
  input wire logic input_terminal_three,
  input wire logic input_terminal_four,
  input wire logic input_terminal_five,
  input wire logic [4:0] func_sel_one,
  input wire logic [4:0] func_sel_two,
  input wire logic [4:0] func_sel_three,
  input wire logic [4:0] func_sel_four,
  input wire logic [4:0] func_sel_five,
  input wire logic [1:0] run_mode_sel,
  input wire logic [8:0] scan_time_ms,
  input wire logic [4:0] polarity_sel,
  input wire logic [15:0] updown_step,
  input wire logic [15:0] upper_limit,
  input wire logic [1:0] keep_status,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] set_freq,
  output logic run_cmd,
  output logic reverse_cmd,
  output logic jog_fwd,
  output logic jog_rev,
  output logic [2:0] preset_index,
  output logic [15:0] updown_freq,
  output logic updown_enabled,
  output logic updown_ramping,
  output logic accel_set_two,
  output logic ramp_hold,
  output logic alt_run_src,
  output logic alt_freq_src,
  output logic rapid_stop,
  output logic coast_block,
  output logic sweep_active,
  output logic [15:0] sweep_freq,
  output logic pid_disable,
  output logic fault_reset,
  output logic auto_seq_en,
  output logic keypad_freq_load,
  output logic [15:0] keypad_freq
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic fn_on(input logic [NTERM-1:0] lvl,
                                 input logic [NTERM*5-1:0] fsel,
                                 input logic [NTERM-1:0] use_mask,
                                 input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (use_mask[i] && lvl[i] && fsel[i*5 +: 5] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] lim);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, lim}) ? lim : s[15:0];
  endfunction

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : 16'h0000;
  endfunction

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic [31:0] div_cnt;
  logic tick;
  wire div_end = (div_cnt == 32'(TICK_DIV - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      div_cnt <= div_end ? 32'h0 : div_cnt + 32'h1;
      tick <= div_end;
    end
  end

  // ---------------------------------------------------------------
  // Noise filter and polarity
  // ---------------------------------------------------------------
  wire [NTERM-1:0] raw = {input_terminal_five, input_terminal_four, input_terminal_three,
                          input_terminal_two, input_terminal_one};
  wire [NTERM*5-1:0] fsel = {func_sel_five, func_sel_four, func_sel_three,
                             func_sel_two, func_sel_one};
  wire [NTERM-1:0] corr = raw ^ polarity_sel;
  wire [8:0] scan_lim = (scan_time_ms < SCAN_MIN_MS) ? SCAN_MIN_MS :
                        (scan_time_ms > SCAN_MAX_MS) ? SCAN_MAX_MS : scan_time_ms;
  logic [NTERM-1:0] lvl;
  logic [8:0] flt_cnt [NTERM];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl <= '0;
      for (int i = 0; i < NTERM; i++) flt_cnt[i] <= 9'h0;
    end else begin
      for (int i = 0; i < NTERM; i++) begin
        if (corr[i] == lvl[i]) begin
          flt_cnt[i] <= 9'h0;
        end else if (tick) begin
          if (flt_cnt[i] + 9'h1 >= scan_lim) begin
            lvl[i] <= corr[i];
            flt_cnt[i] <= 9'h0;
          end else begin
            flt_cnt[i] <= flt_cnt[i] + 9'h1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Function decode
  // ---------------------------------------------------------------
  wire wire3 = (run_mode_sel == WIRE3_MODE);
  wire [NTERM-1:0] use_mask = wire3 ? 5'h18 : 5'h1f;
  wire f_fwd = fn_on(lvl, fsel, use_mask, FN_FWD_RUN);
  wire f_rev = fn_on(lvl, fsel, use_mask, FN_REV_DIR);
  wire f_pa = fn_on(lvl, fsel, use_mask, FN_PRESET_A);
  wire f_pb = fn_on(lvl, fsel, use_mask, FN_PRESET_B);
  wire f_pc = fn_on(lvl, fsel, use_mask, FN_PRESET_C);
  wire f_jf = fn_on(lvl, fsel, use_mask, FN_JOG_FWD);
  wire f_jr = fn_on(lvl, fsel, use_mask, FN_JOG_REV);
  wire f_up = fn_on(lvl, fsel, use_mask, FN_UP);
  wire f_dn = fn_on(lvl, fsel, use_mask, FN_DOWN);
  wire f_rs = fn_on(lvl, fsel, use_mask, FN_RAPID_STOP);
  wire f_bb = fn_on(lvl, fsel, use_mask, FN_COAST);
  wire f_fr = fn_on(lvl, fsel, use_mask, FN_FAULT_RST);
  wire f_auto = fn_on(5'h1f, fsel, use_mask, FN_AUTO_SEQ);

  // ---------------------------------------------------------------
  // Run and direction
  // ---------------------------------------------------------------
  logic wire3_run;
  logic run_base_q;
  logic up_q;
  logic dn_q;
  logic bb_q;
  logic fr_q;
  logic rapid_latch;
  wire next_wire3_run = (!wire3 || lvl[1]) ? 1'b0 : (lvl[0] ? 1'b1 : wire3_run);
  wire run_base = (run_mode_sel == WIRE2_MODE1) ? (f_fwd ^ f_rev) :
                  (run_mode_sel == WIRE2_MODE2) ? f_fwd :
                  wire3 ? wire3_run : 1'b0;
  wire dir_rev = (run_mode_sel == WIRE2_MODE1) ? (f_rev & ~f_fwd) :
                 (run_mode_sel == WIRE2_MODE2) ? f_rev : wire3 & lvl[2];
  wire run_rise = run_base & ~run_base_q;
  wire next_rapid = f_rs | (rapid_latch & ~run_rise);
  wire jog_both = f_jf & f_jr;
  wire run_eff = run_base & ~next_rapid & ~f_bb & ~jog_both;
  wire stop_evt = run_cmd & ~run_eff;

  // ---------------------------------------------------------------
  // Up/down frequency
  // ---------------------------------------------------------------
  logic [11:0] ud_ms;
  wire ud_held = f_up | f_dn;
  wire ud_ramp = (ud_ms == UD_HOLD_MS);
  wire up_edge = f_up & ~up_q;
  wire dn_edge = f_dn & ~dn_q;
  wire [15:0] step = (updown_step > UD_STEP_MAX) ? UD_STEP_MAX : updown_step;
  wire up_go = updown_enabled & ~f_dn & (up_edge | (ud_ramp & tick));
  wire dn_go = updown_enabled & ~f_up & (dn_edge | (ud_ramp & tick));
  wire [15:0] up_amt = ud_ramp ? RAMP_STEP : step;
  wire [15:0] next_updown_freq =
    (stop_evt && keep_status == KEEP_ZERO) ? 16'h0000 :
    up_go ? sat_add(updown_freq, up_amt, upper_limit) :
    dn_go ? sat_sub(updown_freq, up_amt) : updown_freq;
  wire next_ud_en = (stop_evt && keep_status == KEEP_HOLD_OFF) ? 1'b0 :
                    run_rise ? 1'b1 : updown_enabled;
  wire [11:0] next_ud_ms = !ud_held ? 12'h0 :
                           (tick && !ud_ramp) ? ud_ms + 12'h1 : ud_ms;

  // ---------------------------------------------------------------
  // Coast-block release sweep
  // ---------------------------------------------------------------
  wire [15:0] sweep_top = sat_add(set_freq, SWEEP_OFFSET, upper_limit);
  wire bb_fall = bb_q & ~f_bb;
  wire sweep_done = sweep_active & tick & (sweep_freq >= sweep_top);
  wire next_sweep_active = bb_fall | (sweep_active & ~sweep_done & ~f_bb);
  wire [15:0] next_sweep_freq = bb_fall ? sat_sub(set_freq, SWEEP_OFFSET) :
                                sweep_done ? set_freq :
                                (sweep_active && tick) ? sweep_freq + RAMP_STEP : sweep_freq;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wire3_run <= 1'b0;
      run_base_q <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      bb_q <= 1'b0;
      fr_q <= 1'b0;
      rapid_latch <= 1'b0;
      ud_ms <= 12'h0;
      run_cmd <= 1'b0;
      reverse_cmd <= 1'b0;
      jog_fwd <= 1'b0;
      jog_rev <= 1'b0;
      preset_index <= 3'h0;
      updown_freq <= 16'h0000;
      updown_enabled <= 1'b1;
      updown_ramping <= 1'b0;
      accel_set_two <= 1'b0;
      ramp_hold <= 1'b0;
      alt_run_src <= 1'b0;
      alt_freq_src <= 1'b0;
      rapid_stop <= 1'b0;
      coast_block <= 1'b0;
      sweep_active <= 1'b0;
      sweep_freq <= 16'h0000;
      pid_disable <= 1'b0;
      fault_reset <= 1'b0;
      auto_seq_en <= 1'b0;
      keypad_freq_load <= 1'b0;
      keypad_freq <= 16'h0000;
    end else begin
      wire3_run <= next_wire3_run;
      run_base_q <= run_base;
      up_q <= f_up;
      dn_q <= f_dn;
      bb_q <= f_bb;
      fr_q <= f_fr;
      rapid_latch <= next_rapid;
      ud_ms <= next_ud_ms;
      run_cmd <= run_eff;
      reverse_cmd <= dir_rev;
      jog_fwd <= f_jf & ~jog_both;
      jog_rev <= f_jr & ~jog_both;
      preset_index <= {f_pa, f_pb, f_pc};
      updown_freq <= next_updown_freq;
      updown_enabled <= next_ud_en;
      updown_ramping <= ud_ramp;
      accel_set_two <= fn_on(lvl, fsel, use_mask, FN_ACC2) | next_rapid;
      ramp_hold <= fn_on(lvl, fsel, use_mask, FN_RAMP_HOLD);
      alt_run_src <= fn_on(lvl, fsel, use_mask, FN_ALT_RUN);
      alt_freq_src <= fn_on(lvl, fsel, use_mask, FN_ALT_FREQ);
      rapid_stop <= next_rapid;
      coast_block <= f_bb;
      sweep_active <= next_sweep_active;
      sweep_freq <= next_sweep_freq;
      pid_disable <= fn_on(lvl, fsel, use_mask, FN_PID_OFF);
      fault_reset <= f_fr & ~fr_q;
      auto_seq_en <= f_auto;
      keypad_freq_load <= stop_evt && keep_status != KEEP_ZERO;
      if (stop_evt && keep_status != KEEP_ZERO) begin
        keypad_freq <= output_freq;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_two_both;
    run_mode_sel == WIRE2_MODE1 && f_fwd && f_rev;
  endsequence
  sequence s_stopped;
    !run_cmd && !reverse_cmd;
  endsequence

  AST_TWO_WIRE_BOTH: assert property (s_two_both |=> s_stopped)
    else $error("both two-wire inputs did not stop");
  AST_MODE2_DIR: assert property (run_mode_sel == WIRE2_MODE2 |=>
      reverse_cmd == $past(f_rev))
    else $error("mode two direction wrong");
  AST_WIRE3_STOP: assert property (wire3 && lvl[1] |=> !wire3_run ##1 !run_cmd)
    else $error("three-wire stop ignored");
  AST_PRESET: assert property (1'b1 |=> preset_index == {$past(f_pa), $past(f_pb), $past(f_pc)})
    else $error("preset index wrong");
  AST_JOG_BOTH: assert property (jog_both |=> !jog_fwd && !jog_rev && !run_cmd)
    else $error("jog both did not stop");
  AST_UP_STEP: assert property (up_edge && up_go && !ud_ramp && !stop_evt |=>
      updown_freq == sat_add($past(updown_freq), $past(step), $past(upper_limit)))
    else $error("up step wrong");
  AST_RAMP_AFTER_HOLD: assert property (ud_held && ud_ms == UD_HOLD_MS |=> updown_ramping)
    else $error("ramp not entered after hold");
  AST_RAPID_LATCH: assert property ($fell(f_rs) && !run_rise |=> rapid_stop && !run_cmd)
    else $error("rapid stop released early");
  AST_SWEEP_START: assert property (bb_fall |=> sweep_active &&
      sweep_freq == sat_sub($past(set_freq), SWEEP_OFFSET))
    else $error("sweep start wrong");
  AST_KEEP_ZERO: assert property (stop_evt && keep_status == KEEP_ZERO |=>
      updown_freq == 16'h0000 && !keypad_freq_load)
    else $error("keep zero not applied");
  AST_KEYPAD_COPY: assert property (stop_evt && keep_status != KEEP_ZERO |=>
      keypad_freq_load && keypad_freq == $past(output_freq))
    else $error("keypad copy missing");
  AST_FILTER_HOLD: assert property (corr[0] != lvl[0] && !tick |=> lvl[0] == $past(lvl[0]))
    else $error("filter changed level off tick");
endmodule // mfi_decoder
`default_nettype wire

// File: pkg/mfi_pkg.sv
// Constants shared by the multifunction input decoder
`default_nettype none
package mfi_pkg;
  // ---------------------------------------------------------------
  // Terminal function codes
  // ---------------------------------------------------------------
  localparam logic [4:0] FN_FWD_RUN = 5'h00;
  localparam logic [4:0] FN_REV_DIR = 5'h01;
  localparam logic [4:0] FN_PRESET_C = 5'h02;
  localparam logic [4:0] FN_PRESET_B = 5'h03;
  localparam logic [4:0] FN_PRESET_A = 5'h04;
  localparam logic [4:0] FN_JOG_FWD = 5'h06;
  localparam logic [4:0] FN_JOG_REV = 5'h07;
  localparam logic [4:0] FN_UP = 5'h08;
  localparam logic [4:0] FN_DOWN = 5'h09;
  localparam logic [4:0] FN_ACC2 = 5'h0a;
  localparam logic [4:0] FN_RAMP_HOLD = 5'h0b;
  localparam logic [4:0] FN_ALT_RUN = 5'h0c;
  localparam logic [4:0] FN_ALT_FREQ = 5'h0d;
  localparam logic [4:0] FN_RAPID_STOP = 5'h0e;
  localparam logic [4:0] FN_COAST = 5'h0f;
  localparam logic [4:0] FN_PID_OFF = 5'h10;
  localparam logic [4:0] FN_FAULT_RST = 5'h11;
  localparam logic [4:0] FN_AUTO_SEQ = 5'h12;
  // ---------------------------------------------------------------
  // Run wiring modes and keep-status settings
  // ---------------------------------------------------------------
  localparam logic [1:0] WIRE2_MODE1 = 2'h0;
  localparam logic [1:0] WIRE2_MODE2 = 2'h1;
  localparam logic [1:0] WIRE3_MODE = 2'h2;
  localparam logic [1:0] KEEP_HOLD_OFF = 2'h0;
  localparam logic [1:0] KEEP_ZERO = 2'h1;
  localparam logic [1:0] KEEP_HOLD_ON = 2'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int UD_HOLD_S = 2;
  localparam logic [11:0] UD_HOLD_MS = 12'(UD_HOLD_S * 1000);
  localparam logic [8:0] SCAN_MIN_MS = 9'h001;
  localparam logic [8:0] SCAN_MAX_MS = 9'h190;
  // Frequencies in 0.01 Hz units
  localparam logic [15:0] SWEEP_OFFSET = 16'h01f4;
  localparam logic [15:0] UD_STEP_MAX = 16'h01f4;
  localparam logic [15:0] RAMP_STEP = 16'h0001;
endpackage
`default_nettype wire

// File: test/mfi_switch_bank.sv
// Switch bank model that drives the five input terminals
`default_nettype none
module mfi_switch_bank #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic [4:0] lvl,
  input wire logic chatter,
  output logic [4:0] term
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic flip = 1'b0;
  // Contact bounce: level flips every HALF cycles, never stable for two ticks
  always_ff @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      flip <= ~flip;
    end
  end
  assign term = chatter ? (lvl ^ {5{flip}}) : lvl;
endmodule // mfi_switch_bank
`default_nettype wire

// File: test/tb_mfi_decoder.sv
// Self-checking bench for the multifunction input decoder
`default_nettype none
module tb_mfi_decoder import mfi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 4;
  localparam int SETTLE = 4 * TD + 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] lvl = '0;
  logic chatter = 1'b0;
  logic [4:0] term;
  logic [4:0] fs [5];
  logic [4:0] codes [5];
  logic [1:0] jx [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  logic [1:0] mode = 2'h3;
  logic [4:0] pol = '0;
  logic [8:0] scan = 9'h002;
  logic [15:0] ud_step = 16'h0064;
  logic [15:0] lim = 16'h00fa;
  logic [1:0] keep = 2'h2;
  logic [15:0] ofreq = '0;
  logic [15:0] sfreq = 16'h1000;
  logic [15:0] exp_f = '0;
  logic [15:0] f0;
  logic [31:0] rng = 32'hd2854658;
  logic run_cmd, reverse_cmd, jog_fwd, jog_rev, updown_enabled, updown_ramping;
  logic accel_set_two, ramp_hold, alt_run_src, alt_freq_src, rapid_stop, coast_block;
  logic sweep_active, pid_disable, fault_reset, auto_seq_en, keypad_freq_load;
  logic [2:0] preset_index;
  logic [15:0] updown_freq, sweep_freq, keypad_freq;
  wire [4:0] lvl_out = {accel_set_two, ramp_hold, alt_run_src, alt_freq_src, pid_disable};
  int failures = 0;
  int n_tests = 0;
  int n_load = 0;
  int n_fault = 0;
  int n0;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [15:0] ud_exp(input logic [15:0] f, input logic up);
    if (up) return (17'(f) + ud_step > lim) ? lim : f + ud_step;
    return (f > ud_step) ? f - ud_step : 16'h0000;
  endfunction
  task automatic step_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic drive(input logic [4:0] v);
    lvl = v;
    step_n(SETTLE);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  mfi_switch_bank #(.HALF(TD)) mfi_switch_bank_i (.clk(clk), .lvl(lvl), .chatter(chatter),
    .term(term));
  mfi_decoder #(.TICK_DIV(TD)) mfi_decoder_i (.clk(clk), .rstn(rstn),
    .input_terminal_one(term[0]), .input_terminal_two(term[1]),
    .input_terminal_three(term[2]), .input_terminal_four(term[3]),
    .input_terminal_five(term[4]), .func_sel_one(fs[0]), .func_sel_two(fs[1]),
    .func_sel_three(fs[2]), .func_sel_four(fs[3]), .func_sel_five(fs[4]),
    .run_mode_sel(mode), .scan_time_ms(scan), .polarity_sel(pol), .updown_step(ud_step),
    .upper_limit(lim), .keep_status(keep), .output_freq(ofreq), .set_freq(sfreq),
    .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .jog_fwd(jog_fwd), .jog_rev(jog_rev),
    .preset_index(preset_index), .updown_freq(updown_freq), .updown_enabled(updown_enabled),
    .updown_ramping(updown_ramping), .accel_set_two(accel_set_two), .ramp_hold(ramp_hold),
    .alt_run_src(alt_run_src), .alt_freq_src(alt_freq_src), .rapid_stop(rapid_stop),
    .coast_block(coast_block), .sweep_active(sweep_active), .sweep_freq(sweep_freq),
    .pid_disable(pid_disable), .fault_reset(fault_reset), .auto_seq_en(auto_seq_en),
    .keypad_freq_load(keypad_freq_load), .keypad_freq(keypad_freq));

  initial begin
    forever #4 clk = ~clk;
  end
  // Pulse counters
  always @(posedge clk) begin
    if (keypad_freq_load === 1'b1) n_load <= n_load + 1;
    if (fault_reset === 1'b1) n_fault <= n_fault + 1;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("timeout");
    report_and_stop();
  end

  initial begin
    fs = '{FN_AUTO_SEQ, FN_AUTO_SEQ, FN_AUTO_SEQ, FN_AUTO_SEQ, FN_AUTO_SEQ};
    step_n(16);
    rstn = 1'b1;
    step_n(2);
    chk("updown_en", 1, updown_enabled);
    chk("auto_seq", 1, auto_seq_en);
    fs = '{FN_PRESET_A, FN_PRESET_B, FN_PRESET_C, FN_UP, FN_DOWN};
    step_n(2);
    chk("auto_seq_off", 0, auto_seq_en);
    for (int k = 0; k < 6; k++) begin
      rng = lfsr(rng);
      drive(k == 0 ? 5'h07 : {2'b00, rng[2:0]});
      chk("preset", {lvl[0], lvl[1], lvl[2]}, preset_index);
    end
    drive(5'h00);
    chatter = 1'b1;
    step_n(SETTLE * 4);
    chk("chatter", 0, preset_index);
    chatter = 1'b0;
    drive(5'h00);
    lvl = 5'h07;
    step_n(TD - 1);
    lvl = 5'h00;
    step_n(2);
    chk("glitch", 0, preset_index);
    scan = 9'h000;
    lvl = 5'h07;
    step_n(TD + 1);
    chk("scan_min", 7, preset_index);
    scan = 9'h002;
    pol = 5'h01;
    drive(5'h00);
    chk("polarity", 4, preset_index);
    pol = 5'h00;
    drive(5'h00);
    $display("test filter and preset done");
    for (int k = 0; k < 8; k++) begin
      drive(k < 4 ? 5'h08 : 5'h10);
      exp_f = ud_exp(exp_f, k < 4);
      chk("updown", exp_f, updown_freq);
      drive(5'h00);
    end
    chk("ramping", 0, updown_ramping);
    lim = 16'hffff;
    drive(5'h08);
    step_n(2003 * TD);
    chk("ramping", 1, updown_ramping);
    chk("ramp_freq", 1, updown_freq > ud_step);
    drive(5'h00);
    $display("test updown done");
    mode = WIRE2_MODE1;
    fs[0] = FN_FWD_RUN;
    fs[1] = FN_REV_DIR;
    for (int k = 1; k < 4; k++) begin
      drive(5'(k));
      chk("mode1_run", k != 3, run_cmd);
      if (k < 3) chk("mode1_rev", k == 2, reverse_cmd);
      drive(5'h00);
    end
    mode = WIRE2_MODE2;
    for (int k = 1; k < 4; k++) begin
      drive(5'(k));
      chk("mode2_run", k[0], run_cmd);
      if (k != 2) chk("mode2_rev", k[1], reverse_cmd);
      drive(5'h00);
    end
    mode = WIRE3_MODE;
    fs = '{FN_PRESET_A, FN_PRESET_B, FN_PRESET_C, FN_UP, FN_DOWN};
    drive(5'h01);
    chk("w3_run", 1, run_cmd);
    chk("w3_nodecode", 0, preset_index);
    drive(5'h05);
    chk("w3_rev", 1, reverse_cmd);
    drive(5'h07);
    chk("w3_stop", 0, run_cmd);
    drive(5'h00);
    $display("test run modes done");
    mode = WIRE2_MODE1;
    fs[0] = FN_FWD_RUN;
    for (int k = 0; k < 3; k++) begin
      keep = 2'(k);
      rng = lfsr(rng);
      ofreq = rng[15:0];
      drive(5'h01);
      drive(5'h09);
      drive(5'h01);
      n0 = n_load;
      drive(5'h00);
      chk("keypad_load", n0 + (k != 1), n_load);
      if (k != 1) chk("keypad_freq", ofreq, keypad_freq);
      if (k == 1) chk("keep_zero", 0, updown_freq);
      chk("updown_en_stop", k != 0, updown_enabled);
      f0 = updown_freq;
      drive(5'h08);
      if (k != 1) chk("keep_updown", k == 2 ? ud_exp(f0, 1'b1) : f0, updown_freq);
      drive(5'h00);
    end
    $display("test keep status done");
    codes = '{FN_ACC2, FN_RAMP_HOLD, FN_ALT_RUN, FN_ALT_FREQ, FN_PID_OFF};
    for (int k = 0; k < 5; k++) begin
      fs[3] = codes[k];
      drive(5'h08);
      chk("level_fn", 5'h10 >> k, lvl_out);
      drive(5'h00);
      chk("level_fn_off", 0, lvl_out);
    end
    fs[3] = FN_JOG_FWD;
    fs[4] = FN_JOG_REV;
    for (int k = 1; k < 4; k++) begin
      drive(5'(k << 3));
      chk("jog", jx[k], {jog_fwd, jog_rev});
      drive(5'h00);
    end
    fs[3] = FN_FAULT_RST;
    n0 = n_fault;
    drive(5'h08);
    drive(5'h00);
    chk("fault_reset", n0 + 1, n_fault);
    $display("test level functions done");
    fs[3] = FN_RAPID_STOP;
    drive(5'h08);
    chk("rapid_on", 1, rapid_stop);
    drive(5'h00);
    chk("rapid_latch", 1, rapid_stop);
    chk("rapid_dec2", 1, accel_set_two);
    drive(5'h01);
    chk("rapid_clear", 0, rapid_stop);
    drive(5'h00);
    fs[4] = FN_COAST;
    drive(5'h10);
    chk("coast", 1, coast_block);
    drive(5'h00);
    chk("sweep_on", 1, sweep_active);
    chk("sweep_lo", 1, sweep_freq >= sfreq - SWEEP_OFFSET && sweep_freq < sfreq);
    step_n(1010 * TD);
    chk("sweep_off", 0, sweep_active);
    chk("sweep_end", sfreq, sweep_freq);
    $display("test stop functions done");
    report_and_stop();
  end
endmodule // tb_mfi_decoder
`default_nettype wire
